// [include/rbs_pkg.sv]
`default_nettype none
package rbs_pkg;

    // reference clock cycles the core stays halted while the pll locks
    localparam int unsigned LOCK_CYCLES   = 4096;
    localparam logic [31:0] RESET_VECTOR  = 32'h0009_0000;

    localparam int unsigned BOOT_W        = 3;
    localparam int unsigned RATIO_W       = 6;

    // clock configuration strap encodings
    localparam logic [1:0] CLK_CFG_6      = 2'h0;
    localparam logic [1:0] CLK_CFG_32     = 2'h1;
    localparam logic [1:0] CLK_CFG_16     = 2'h2;
    localparam logic [1:0] CLK_CFG_RSVD   = 2'h3;

    // core to reference clock ratios
    localparam logic [5:0] RATIO_6        = 6'h06;
    localparam logic [5:0] RATIO_32       = 6'h20;
    localparam logic [5:0] RATIO_16       = 6'h10;
    localparam logic [5:0] RATIO_NONE     = 6'h00;

    // reset values
    localparam logic [2:0] BOOT_MODE_RST  = 3'h0;
    localparam logic       PIN_LVL_RST    = 1'b0;
    localparam logic       PIN_OE_RST     = 1'b1;

    typedef enum logic [1:0] {
        ST_LOCK   = 2'b00,
        ST_FETCH  = 2'b01,
        ST_RUN    = 2'b11,
        ST_RUNRST = 2'b10
    } rbs_state_t;

    typedef struct packed {
        logic [BOOT_W-1:0]  boot_mode;
        logic [RATIO_W-1:0] clk_ratio;
        logic               ratio_rsvd;
    } rbs_cfg_t;

endpackage
`default_nettype wire

// [rtl/rbs_lock_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module rbs_lock_counter
    import rbs_pkg::*;
#(
    parameter int unsigned CYCLES = LOCK_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic clear_in,
    output var  logic done_out
);

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_ff;

    // counter parks at its last value so done stays high until cleared
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= '0;
        end else if (clear_in) begin
            cnt_ff <= '0;
        end else if (cnt_ff != LAST) begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= !clear_in && (cnt_ff == LAST);
        end
    end

endmodule
`default_nettype wire

// [rtl/rbs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer
    import rbs_pkg::*;
#(
    parameter int unsigned LOCK_CNT = LOCK_CYCLES,
    parameter logic [31:0] VECTOR   = RESET_VECTOR
) (
    input  wire logic              CLK_SYS_IN,
    input  wire logic              RST_IN,
    input  wire logic [BOOT_W-1:0] BOOT_CFG_IN,
    input  wire logic [1:0]        CLK_CFG_IN,
    input  wire logic              RUNNING_RESET_CONTROL_IN,
    input  wire logic              RESET_PIN_IN,
    output var  logic              RESET_PIN_OUT,
    output var  logic              RESET_PIN_OE_OUT,
    output var  logic              CORE_RESET_OUT,
    output var  logic              FETCH_START_OUT,
    output var  logic [31:0]       FETCH_ADDR_OUT,
    output var  rbs_cfg_t          CFG_OUT
);

    function automatic logic [RATIO_W-1:0] ratio_of(input logic [1:0] code);
        logic [RATIO_W-1:0] r;
        r = RATIO_NONE;
        unique case (code)
            CLK_CFG_6:    r = RATIO_6;
            CLK_CFG_32:   r = RATIO_32;
            CLK_CFG_16:   r = RATIO_16;
            CLK_CFG_RSVD: r = RATIO_NONE;
        endcase
        return r;
    endfunction

    rbs_state_t state_ff;
    rbs_state_t nxt_state;
    logic       lock_done;
    logic       role_in_ff;
    logic       straps_taken_ff;
    logic       run_reset_req;

    // one register per field so each concern keeps its own process
    logic [RATIO_W-1:0] ratio_ff;
    logic               ratio_rsvd_ff;
    logic [BOOT_W-1:0]  boot_mode_ff;

    assign CFG_OUT = '{boot_mode: boot_mode_ff, clk_ratio: ratio_ff, ratio_rsvd: ratio_rsvd_ff};

    rbs_lock_counter #(
        .CYCLES   (LOCK_CNT)
    ) u_lock (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .clear_in (state_ff != ST_LOCK),
        .done_out (lock_done)
    );

    // pin is active low; only listened to in its input role
    assign run_reset_req = role_in_ff && !RESET_PIN_IN;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_LOCK: begin
                if (lock_done) begin
                    nxt_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (run_reset_req) begin
                    nxt_state = ST_RUNRST;
                end
            end
            ST_RUNRST: begin
                // no pll relock: the reference clock kept running
                if (!run_reset_req) begin
                    nxt_state = ST_FETCH;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_ff <= ST_LOCK;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CORE_RESET_OUT <= 1'b1;
        end else begin
            CORE_RESET_OUT <= (nxt_state == ST_LOCK) || (nxt_state == ST_RUNRST);
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            FETCH_START_OUT <= 1'b0;
            FETCH_ADDR_OUT  <= 32'h0000_0000;
        end else begin
            FETCH_START_OUT <= (nxt_state == ST_FETCH);
            FETCH_ADDR_OUT  <= VECTOR;
        end
    end

    // role changes only outside hardware reset; the control input is synchronous
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            role_in_ff <= 1'b0;
        end else begin
            role_in_ff <= RUNNING_RESET_CONTROL_IN;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RESET_PIN_OE_OUT <= PIN_OE_RST;
            RESET_PIN_OUT    <= PIN_LVL_RST;
        end else begin
            RESET_PIN_OE_OUT <= !RUNNING_RESET_CONTROL_IN;
            RESET_PIN_OUT    <= (nxt_state == ST_FETCH) || (nxt_state == ST_RUN);
        end
    end

    // straps cannot be caught under the async reset, so the first clocked cycle takes them
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            straps_taken_ff <= 1'b0;
            ratio_ff        <= RATIO_NONE;
            ratio_rsvd_ff   <= 1'b0;
        end else if (!straps_taken_ff) begin
            straps_taken_ff <= 1'b1;
            ratio_ff        <= ratio_of(CLK_CFG_IN);
            ratio_rsvd_ff   <= (CLK_CFG_IN == CLK_CFG_RSVD);
        end
    end

    // boot mode is sampled at every core release, hardware or running reset
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            boot_mode_ff <= BOOT_MODE_RST;
        end else if (nxt_state == ST_FETCH) begin
            boot_mode_ff <= BOOT_CFG_IN;
        end
    end

    // helper: cycles spent in the lock state
    logic [15:0] hold_cnt_ff;

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            hold_cnt_ff <= 16'h0000;
        end else if (state_ff == ST_LOCK) begin
            hold_cnt_ff <= hold_cnt_ff + 16'h0001;
        end
    end

    AST_LOCK_MIN: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state_ff == ST_LOCK && nxt_state == ST_FETCH) |-> (hold_cnt_ff >= 16'(LOCK_CNT)))
        else $error("core released before lock interval");

    AST_LOCK_MAX: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state_ff == ST_LOCK) |-> (hold_cnt_ff <= 16'(LOCK_CNT + 1)))
        else $error("lock interval overran");

    AST_HALT_IN_LOCK: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state_ff == ST_LOCK) |-> CORE_RESET_OUT)
        else $error("core not halted during lock");

    AST_FETCH_VECTOR: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        $fell(CORE_RESET_OUT) |-> FETCH_START_OUT && FETCH_ADDR_OUT == VECTOR)
        else $error("release without fetch at reset vector");

    AST_FETCH_PULSE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        FETCH_START_OUT |=> !FETCH_START_OUT)
        else $error("fetch start longer than one cycle");

    AST_PIN_TRACKS: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        RESET_PIN_OE_OUT |-> (RESET_PIN_OUT == !CORE_RESET_OUT))
        else $error("reset output does not follow core halt");

    AST_ROLE_SWITCH: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        RUNNING_RESET_CONTROL_IN |=> !RESET_PIN_OE_OUT)
        else $error("pin still driven in input role");

    AST_RUNRST_HALT: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state_ff == ST_RUN && role_in_ff && !RESET_PIN_IN) |=> CORE_RESET_OUT && (state_ff == ST_RUNRST))
        else $error("running reset ignored");

    AST_FETCH_AFTER_HALT: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        FETCH_START_OUT |-> $past(CORE_RESET_OUT))
        else $error("fetch started without a preceding halt");

    AST_PIN_LOW_IN_LOCK: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state_ff == ST_LOCK) |-> !RESET_PIN_OUT)
        else $error("reset output released during lock");

    AST_BOOT_MODE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (nxt_state == ST_FETCH) |=> (CFG_OUT.boot_mode == $past(BOOT_CFG_IN)))
        else $error("boot mode not sampled at release");

    AST_RATIO: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (!straps_taken_ff && CLK_CFG_IN == CLK_CFG_32) |=> (CFG_OUT.clk_ratio == RATIO_32))
        else $error("clock ratio strap misdecoded");

    COV_BOOT: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN) $fell(CORE_RESET_OUT));
    COV_RUNRST: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN) state_ff == ST_RUNRST);
    COV_RSVD: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN) straps_taken_ff && ratio_rsvd_ff);
    COV_REBOOT: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        state_ff == ST_RUNRST ##1 FETCH_START_OUT);

endmodule
`default_nettype wire

// [bench/rbs_board_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rbs_board_model
    import rbs_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              hw_req_in,
    input  wire logic              pull_req_in,
    input  wire logic [BOOT_W-1:0] boot_in,
    input  wire logic [1:0]        ccfg_in,
    output var  logic              hw_rst_out,
    output var  logic              pull_low_out,
    output var  logic [BOOT_W-1:0] boot_out,
    output var  logic [1:0]        ccfg_out
);
    // one process owns every output so each has a single driver
    initial begin
        hw_rst_out   = 1'b1;
        pull_low_out = 1'b0;
        boot_out     = '0;
        ccfg_out     = 2'h0;
        forever begin
            @(posedge clk_in);
            // straps move only while a reset is already held, so they are settled at each release
            if ((hw_req_in && hw_rst_out) || (pull_req_in && pull_low_out)) begin
                boot_out <= boot_in;
                ccfg_out <= ccfg_in;
            end
            hw_rst_out   <= hw_req_in;
            pull_low_out <= pull_req_in;
        end
    end
endmodule
`default_nettype wire

// [bench/processor_reset_boot_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module processor_reset_boot_sequencer_test
    import rbs_pkg::*;
;
    localparam int LOCK = 8;
    logic        clk, hw_req, pull_req, ctl, rst, pull_low, pin_lvl;
    logic        pin_out, pin_oe, core_rst, fetch;
    logic [31:0] addr;
    logic [2:0]  boot_sel, boot_cfg;
    logic [1:0]  clk_sel, clk_cfg;
    rbs_cfg_t    cfg;
    int          failures, cmp_count;

    // pad has a pull-up, so a released pin reads high
    assign pin_lvl = pin_oe ? pin_out : !pull_low;

    rbs_board_model board_u (.clk_in(clk), .hw_req_in(hw_req), .pull_req_in(pull_req), .boot_in(boot_sel),
        .ccfg_in(clk_sel), .hw_rst_out(rst), .pull_low_out(pull_low), .boot_out(boot_cfg), .ccfg_out(clk_cfg));

    rbs_sequencer #(.LOCK_CNT(LOCK)) dut_u (.CLK_SYS_IN(clk), .RST_IN(rst), .BOOT_CFG_IN(boot_cfg),
        .CLK_CFG_IN(clk_cfg), .RUNNING_RESET_CONTROL_IN(ctl), .RESET_PIN_IN(pin_lvl), .RESET_PIN_OUT(pin_out),
        .RESET_PIN_OE_OUT(pin_oe), .CORE_RESET_OUT(core_rst), .FETCH_START_OUT(fetch),
        .FETCH_ADDR_OUT(addr), .CFG_OUT(cfg));

    task automatic final_report();
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_vec(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bounded wait for either the board reset or the core halt to reach a level
    task automatic wait_lvl(input bit on_core, input logic lvl);
        int n;
        n = 0;
        while (((on_core ? core_rst : rst) !== lvl) && n < 20) begin
            @(negedge clk);
            n++;
        end
        if ((on_core ? core_rst : rst) !== lvl) begin
            failures++;
            final_report();
        end
    endtask

    task automatic chk_reset();
        chk_bit("core_reset", 1'b1, core_rst);
        chk_bit("pin_oe", 1'b1, pin_oe);
        chk_bit("pin_out", 1'b0, pin_out);
        chk_bit("fetch_start", 1'b0, fetch);
        chk_vec("fetch_addr", 32'h0000_0000, addr);
        chk_vec("cfg", 32'h0000_0000, 32'(cfg));
    endtask

    task automatic hw_boot(input logic [2:0] b, input logic [1:0] c, input logic [5:0] r);
        rbs_cfg_t e;
        e = '{boot_mode: b, clk_ratio: r, ratio_rsvd: (c == 2'h3)};
        @(posedge clk);
        hw_req   <= 1'b1;
        boot_sel <= b;
        clk_sel  <= c;
        wait_lvl(1'b0, 1'b1);
        repeat (3) @(negedge clk);
        chk_reset();
        @(posedge clk);
        hw_req <= 1'b0;
        wait_lvl(1'b0, 1'b0);
        // halt is seen after the first lock count edges and drops at the edge after them
        for (int i = 1; i <= LOCK; i++) begin
            @(negedge clk);
            chk_bit("core_reset", 1'b1, core_rst);
            chk_bit("pin_out", 1'b0, pin_out);
        end
        @(negedge clk);
        chk_bit("core_reset", 1'b0, core_rst);
        chk_bit("fetch_start", 1'b1, fetch);
        chk_vec("fetch_addr", RESET_VECTOR, addr);
        chk_vec("cfg", 32'(e), 32'(cfg));
        chk_bit("pin_out", 1'b1, pin_out);
        @(negedge clk);
        chk_bit("fetch_start", 1'b0, fetch);
    endtask

    // ratio straps are moved as well: only the boot mode may follow them
    task automatic run_reset();
        rbs_cfg_t e;
        e = '{boot_mode: 3'h6, clk_ratio: RATIO_NONE, ratio_rsvd: 1'b1};
        @(posedge clk);
        ctl <= 1'b1;
        repeat (2) @(negedge clk);
        chk_bit("pin_oe", 1'b0, pin_oe);
        @(posedge clk);
        pull_req <= 1'b1;
        boot_sel <= 3'h6;
        clk_sel  <= 2'h1;
        wait_lvl(1'b1, 1'b1);
        chk_bit("fetch_start", 1'b0, fetch);
        @(posedge clk);
        pull_req <= 1'b0;
        wait_lvl(1'b1, 1'b0);
        chk_bit("fetch_start", 1'b1, fetch);
        chk_vec("cfg", 32'(e), 32'(cfg));
        @(posedge clk);
        ctl <= 1'b0;
        repeat (2) @(negedge clk);
        chk_bit("pin_oe", 1'b1, pin_oe);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        failures  = 0;
        cmp_count = 0;
        hw_req    = 1'b1;
        pull_req  = 1'b0;
        ctl       = 1'b0;
        boot_sel  = 3'h0;
        clk_sel   = 2'h0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk_reset();
        hw_boot(3'h5, CLK_CFG_6, RATIO_6);
        hw_boot(3'h2, CLK_CFG_32, RATIO_32);
        hw_boot(3'h7, CLK_CFG_16, RATIO_16);
        hw_boot(3'h1, CLK_CFG_RSVD, RATIO_NONE);
        run_reset();
        final_report();
    end
endmodule
`default_nettype wire
